//--- core/dsr_sram_port.sv
// Purpose: Device-side logic of a common-I/O DDR SRAM with two-word bursts
// Assumes: All pins, clock pairs included, are sampled by clk; only the clock pairs are edge-detected
// Notes: Link clock period must span several clk cycles (bench: 8)
// Functional notes
// - Address and control taken on input clock rise
// - Write words taken on both input clock rises
// - Output clock pair launches read data
// - Echo strobe edges align with read data
// - Echo strobes run freely, even bus released
// - Bypass low resets and bypasses the DLL
// - Bypass high locks DLL after lock time
// - DLL off cuts read latency by one
// - Address ignored when no access is loaded
// - Active read drives stored words onto bus
// - Output clocks tied high use input clocks
// - Bus released when no read is active
// - Bus width 18 or 36, unused lines idle
// - Direction select: high read, low write
// - Byte write lanes gate each byte written
// - First read word 1.5 cycles, second at 2
`include "dsr_consts.svh"

module dsr_sram_port
   import dsr_pkg::*;
#(
   parameter int ADDR_W = `DSR_ADDR_W,
   parameter int DATA_W = `DSR_DATA_W,
   parameter int FIFO_DEPTH = `DSR_FIFO_DEPTH,
   parameter int TIE_CYC = `DSR_TIE_CYC,
   parameter int LOCK_CYC = `DSR_LOCK_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_timing_pos,
   input wire logic in_timing_neg,
   input wire logic out_timing_pos,
   input wire logic out_timing_neg,
   input wire logic dll_bypass_n,
   input wire logic load_n,
   input wire logic dir_select,
   input wire logic [`DSR_LANES-1:0] byte_write_n,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [`DSR_BUS_W-1:0] data_i,
   output logic [`DSR_BUS_W-1:0] data_o,
   output logic [`DSR_BUS_W-1:0] data_oe,
   output logic echo_strobe_pos,
   output logic echo_strobe_neg,
   output logic dll_locked
);
   localparam int BUS_W = `DSR_BUS_W;
   localparam int BYTE_W = `DSR_BYTE_W;
   localparam int LANES = DATA_W / BYTE_W;
   localparam int SW = `DSR_PIN_FIXED + `DSR_LANES + ADDR_W + BUS_W;
   localparam int TW = $clog2(TIE_CYC + 1);
   localparam int LW = $clog2(LOCK_CYC + 1);
   localparam logic [BUS_W-1:0] USED = BUS_W'({DATA_W{1'b1}});

   if (!(DATA_W == 18 || DATA_W == 36)) begin : g_bad_width
      $error("dsr_sram_port: DATA_W must be 18 or 36");
   end
   if (TIE_CYC < 2 || LOCK_CYC < 1 || ADDR_W < 1) begin : g_bad_count
      $error("dsr_sram_port: TIE_CYC, LOCK_CYC or ADDR_W out of range");
   end

   // Synchronised pin levels
   logic [SW-1:0] pins_s;
   logic k_s;
   logic kn_s;
   logic c_s;
   logic cn_s;
   logic byp_n_s;
   logic ld_s;
   logic dir_s;
   logic [`DSR_LANES-1:0] bw_s;
   logic [ADDR_W-1:0] a_s;
   logic [BUS_W-1:0] d_s;

   dsr_pin_sync #(
      .W(SW)
   ) u_sync (
      .clk(clk),
      .srst(srst),
      .d({in_timing_pos, in_timing_neg, out_timing_pos, out_timing_neg, dll_bypass_n,
          load_n, dir_select, byte_write_n, addr_in, data_i}),
      .q(pins_s)
   );

   assign {k_s, kn_s, c_s, cn_s, byp_n_s, ld_s, dir_s, bw_s, a_s, d_s} = pins_s;

   // Edge detection and launch clock selection
   logic k_d_ff;
   logic kn_d_ff;
   logic lp_d_ff;
   logic ln_d_ff;
   logic k_rise;
   logic kn_rise;
   logic lp;
   logic ln;
   logic lp_rise;
   logic ln_rise;
   logic [TW-1:0] tie_cnt_ff;
   logic tied_ff;

   assign k_rise = k_s && !k_d_ff;
   assign kn_rise = kn_s && !kn_d_ff;
   assign lp = tied_ff ? k_s : c_s;
   assign ln = tied_ff ? kn_s : cn_s;
   assign lp_rise = lp && !lp_d_ff;
   assign ln_rise = ln && !ln_d_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         k_d_ff <= 1'b0;
         kn_d_ff <= 1'b0;
         lp_d_ff <= 1'b0;
         ln_d_ff <= 1'b0;
      end else begin
         k_d_ff <= k_s;
         kn_d_ff <= kn_s;
         lp_d_ff <= lp;
         ln_d_ff <= ln;
      end
   end

   // Both output clocks held high long enough means tied off, not toggling
   always_ff @(posedge clk) begin
      if (srst || !(c_s && cn_s)) begin
         tie_cnt_ff <= '0;
         tied_ff <= 1'b0;
      end else if (tie_cnt_ff == TW'(TIE_CYC - 1)) begin
         tied_ff <= 1'b1;
      end else begin
         tie_cnt_ff <= tie_cnt_ff + 1'b1;
      end
   end

   // DLL model: lock timer restarted while bypassed
   logic [LW-1:0] lock_cnt_ff;
   logic dll_locked_ff;

   always_ff @(posedge clk) begin
      if (srst || !byp_n_s) begin
         lock_cnt_ff <= '0;
         dll_locked_ff <= 1'b0;
      end else if (!dll_locked_ff) begin
         if (lock_cnt_ff == LW'(LOCK_CYC - 1)) begin
            dll_locked_ff <= 1'b1;
         end else begin
            lock_cnt_ff <= lock_cnt_ff + 1'b1;
         end
      end
   end

   assign dll_locked = dll_locked_ff;

   // Command decode; address only loaded with a command
   logic rd_go;
   logic wr_go;

   assign rd_go = k_rise && !ld_s && dir_s;
   assign wr_go = k_rise && !ld_s && !dir_s;

   // Late write: beat 0 on the next input rise, beat 1 on the following neg rise
   logic wr_pend_ff;
   logic [ADDR_W-1:0] wr_addr_ff;
   logic wr_b1_ff;
   logic [ADDR_W-1:0] wr_b1_addr_ff;
   logic we;
   logic [ADDR_W:0] widx;

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_pend_ff <= 1'b0;
         wr_b1_ff <= 1'b0;
      end else begin
         if (k_rise) begin
            wr_pend_ff <= wr_go;
         end
         if (k_rise && wr_pend_ff) begin
            wr_b1_ff <= 1'b1;
         end else if (kn_rise) begin
            wr_b1_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_addr_ff <= '0;
         wr_b1_addr_ff <= '0;
      end else begin
         if (wr_go) begin
            wr_addr_ff <= a_s;
         end
         if (k_rise && wr_pend_ff) begin
            wr_b1_addr_ff <= wr_addr_ff;
         end
      end
   end

   assign we = (k_rise && wr_pend_ff) || (kn_rise && wr_b1_ff);
   assign widx = (k_rise && wr_pend_ff) ? {wr_addr_ff, 1'b0} : {wr_b1_addr_ff, 1'b1};

   // Storage: two words per address, indexed by burst beat
   logic [DATA_W-1:0] mem [2**(ADDR_W+1)];

   always_ff @(posedge clk) begin
      if (we) begin
         for (int g = 0; g < LANES; g++) begin
            if (!bw_s[g]) begin
               mem[widx][g*BYTE_W +: BYTE_W] <= d_s[g*BYTE_W +: BYTE_W];
            end
         end
      end
   end

   // Read fetch into the launch FIFO; stalls while the FIFO is full
   dsr_fetch_t ft_ff;
   logic [ADDR_W-1:0] rd_addr_ff;
   logic fi_valid;
   logic fi_ready;
   logic [DATA_W-1:0] fi_data;
   logic fo_valid;
   logic fo_pop;
   logic [DATA_W-1:0] fo_data;

   assign fi_valid = (ft_ff != ft_idle);
   assign fi_data = mem[{rd_addr_ff, ft_ff == ft_b1}];

   always_ff @(posedge clk) begin
      if (srst) begin
         ft_ff <= ft_idle;
         rd_addr_ff <= '0;
      end else if (rd_go) begin
         ft_ff <= ft_b0;
         rd_addr_ff <= a_s;
      end else if (fi_ready) begin
         unique case (ft_ff)
            ft_idle: ft_ff <= ft_idle;
            ft_b0: ft_ff <= ft_b1;
            ft_b1: ft_ff <= ft_idle;
         endcase
      end
   end

   dsr_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .srst(srst),
      .in_valid(fi_valid),
      .in_ready(fi_ready),
      .in_data(fi_data),
      .out_valid(fo_valid),
      .out_ready(fo_pop),
      .out_data(fo_data)
   );

   // Read latency tokens counted in launch-neg rises
   logic rq_ff;
   logic sh_ff;
   logic launch0;
   logic launch1;
   logic w1_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         rq_ff <= 1'b0;
         sh_ff <= 1'b0;
      end else begin
         rq_ff <= rd_go || (rq_ff && !ln_rise);
         if (ln_rise) begin
            sh_ff <= rq_ff;
         end
      end
   end

   // DLL off: first launch-neg rise; DLL on: the second
   assign launch0 = ln_rise && (byp_n_s ? sh_ff : rq_ff);
   assign launch1 = lp_rise && w1_ff;
   assign fo_pop = (launch0 || launch1) && fo_valid;

   // Output drivers and echo strobes share one register stage for alignment
   logic [BUS_W-1:0] dq_ff;
   logic oe_ff;
   logic echo_p_ff;
   logic echo_n_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         dq_ff <= '0;
         oe_ff <= 1'b0;
         w1_ff <= 1'b0;
      end else if (launch0) begin
         dq_ff <= BUS_W'(fo_data);
         oe_ff <= 1'b1;
         w1_ff <= 1'b1;
      end else if (launch1) begin
         dq_ff <= BUS_W'(fo_data);
         w1_ff <= 1'b0;
      end else if (ln_rise && !w1_ff) begin
         oe_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         echo_p_ff <= 1'b0;
         echo_n_ff <= 1'b0;
      end else begin
         echo_p_ff <= lp;
         echo_n_ff <= ln;
      end
   end

   assign data_o = dq_ff;
   assign data_oe = {BUS_W{oe_ff}} & USED;
   assign echo_strobe_pos = echo_p_ff;
   assign echo_strobe_neg = echo_n_ff;

   // Checks
   cmd_on_k_a: assert property (@(posedge clk) disable iff (srst)
      $rose(wr_pend_ff) |-> $past(k_rise) && !$past(ld_s))
      else $error("write pending set without input clock rise");
   addr_hold_a: assert property (@(posedge clk) disable iff (srst)
      !$past(wr_go) && !$past(srst) |-> wr_addr_ff == $past(wr_addr_ff))
      else $error("write address changed without a load");
   rd_select_a: assert property (@(posedge clk) disable iff (srst)
      (k_rise && !ld_s && dir_s) |=> rq_ff && ft_ff == ft_b0)
      else $error("read command not started");
   wr_beats_a: assert property (@(posedge clk) disable iff (srst)
      (k_rise && wr_pend_ff) |=> wr_b1_ff && wr_b1_addr_ff == $past(wr_addr_ff))
      else $error("second write beat not armed");
   tied_src_a: assert property (@(posedge clk) disable iff (srst)
      tied_ff |-> lp == k_s && ln == kn_s)
      else $error("tied output clocks but launch not from input pair");
   c_src_a: assert property (@(posedge clk) disable iff (srst)
      !tied_ff |-> lp == c_s && ln == cn_s)
      else $error("launch not from output clock pair");
   echo_align_a: assert property (@(posedge clk) disable iff (srst)
      $changed(dq_ff) |-> $changed(echo_p_ff) || $changed(echo_n_ff))
      else $error("read data changed without echo edge");
   echo_free_a: assert property (@(posedge clk) disable iff (srst)
      (!oe_ff && lp_rise) |=> echo_p_ff)
      else $error("echo strobe stopped while bus released");
   dll_reset_a: assert property (@(posedge clk) disable iff (srst)
      !byp_n_s |=> !dll_locked_ff && lock_cnt_ff == '0)
      else $error("dll state kept while bypassed");
   dll_lock_a: assert property (@(posedge clk) disable iff (srst)
      (byp_n_s && !dll_locked_ff && lock_cnt_ff == LW'(LOCK_CYC - 1)) |=> dll_locked_ff)
      else $error("dll failed to lock after lock time");
   lat_off_a: assert property (@(posedge clk) disable iff (srst)
      (!byp_n_s && rq_ff && ln_rise) |=> oe_ff && w1_ff)
      else $error("short latency read word not launched");
   lat_on_a: assert property (@(posedge clk) disable iff (srst)
      (byp_n_s && sh_ff && ln_rise) |=> oe_ff && w1_ff)
      else $error("first read word not launched on second neg rise");
   drive_a: assert property (@(posedge clk) disable iff (srst)
      launch0 |=> data_o[DATA_W-1:0] == $past(fo_data) && data_oe[0])
      else $error("read word not driven");
   release_a: assert property (@(posedge clk) disable iff (srst)
      (ln_rise && !w1_ff && !launch0) |=> !oe_ff)
      else $error("bus not released after burst");
   burst_two_a: assert property (@(posedge clk) disable iff (srst)
      (lp_rise && w1_ff) |=> oe_ff && !w1_ff)
      else $error("second burst word not launched");
   bus_width_a: assert property (@(posedge clk) disable iff (srst)
      (data_oe & ~USED) == '0)
      else $error("unused data line driven");
endmodule : dsr_sram_port

//--- core/dsr_consts.svh
// Purpose: Shared constants for the burst-of-two SRAM pin interface
// Assumes: Included by bare name before any module that needs it
// Notes: Counts are in cycles of the 50 MHz block clock
`ifndef DSR_CONSTS_SVH
`define DSR_CONSTS_SVH
`define DSR_BUS_W 36
`define DSR_BYTE_W 9
`define DSR_LANES 4
`define DSR_DATA_W 36
`define DSR_ADDR_W 19
`define DSR_FIFO_DEPTH 8
`define DSR_TIE_CYC 32
`define DSR_LOCK_CYC 1024
`define DSR_PIN_FIXED 7
`endif

//--- core/dsr_pkg.sv
// Purpose: Types for the burst-of-two SRAM pin interface
// Assumes: Nothing beyond the constants header
// Notes: Read fetch walks the two beats of a burst
package dsr_pkg;
   typedef enum logic [1:0] {ft_idle, ft_b0, ft_b1} dsr_fetch_t;
endpackage : dsr_pkg

//--- core/dsr_pin_sync.sv
// Purpose: Two-stage synchroniser for a bundle of pin inputs
// Assumes: Bits are independent levels; no bus coherency is implied
// Notes: First stage feeds only the second stage
module dsr_pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   if (W < 1) begin : g_bad_w
      $error("dsr_pin_sync: W must be at least 1");
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule : dsr_pin_sync

//--- core/dsr_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock; DEPTH is a power of two
// Notes: Full and empty come from an explicit occupancy count
module dsr_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0] wr_ptr_ff;
   logic [PW-1:0] rd_ptr_ff;
   logic [PW:0] count_ff;
   logic push;
   logic pop;

   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("dsr_fifo: DEPTH must be a power of two, at least 2");
   end

   assign in_ready = (count_ff != (PW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = store[rd_ptr_ff];

   always_ff @(posedge clk) begin
      if (push) begin
         store[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule : dsr_fifo

//--- tb/dsr_ctrl_model.sv
// Purpose: Controller model: link clocks, output clocks, commands, write data
// Assumes: Link period 160 ns; its edges land 2 ns after a clk rise
// Notes: Released data lines show the inverse of the last driven word
module dsr_ctrl_model (
   output logic k_pos,
   output logic k_neg,
   output logic c_pos,
   output logic c_neg,
   output logic load_n,
   output logic dir_select,
   output logic [3:0] byte_write_n,
   output logic [7:0] addr_in,
   output logic [35:0] data_i,
   input wire logic [35:0] dev_d,
   input wire logic [35:0] dev_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tie_c = 1'b0;
   int skew_ns = 0;
   logic c_d = 1'b0;
   logic [35:0] ctrl_d = 36'h0;

   initial begin
      k_pos = 1'b0;
      load_n = 1'b1;
      dir_select = 1'b0;
      byte_write_n = 4'hf;
      addr_in = 8'h00;
      #12;
      forever #80 k_pos = ~k_pos;
   end
   assign k_neg = ~k_pos;
   // Per-device skew of the output pair
   always @(k_pos) c_d <= #(skew_ns) k_pos;
   assign c_pos = tie_c | c_d;
   assign c_neg = tie_c | ~c_d;
   // Shared wire: device wins while its enable is high
   assign data_i = (dev_oe & dev_d) | (~dev_oe & ctrl_d);

   task automatic command(input logic rd, input logic [7:0] a);
      @(negedge k_pos);
      load_n = 1'b0;
      dir_select = rd;
      addr_in = a;
      @(posedge k_pos);
   endtask : command

   // Garbage on the address and direction while nothing is loaded
   task automatic idle();
      @(negedge k_pos);
      load_n = 1'b1;
      dir_select = ~dir_select;
      addr_in = ~addr_in;
   endtask : idle

   task automatic wr_burst(input logic [7:0] a, input logic [35:0] w0, input logic [35:0] w1,
                           input logic [3:0] b0, input logic [3:0] b1);
      command(1'b0, a);
      idle();
      #40 ctrl_d = w0;
      byte_write_n = b0;
      @(posedge k_pos);
      #40 ctrl_d = w1;
      byte_write_n = b1;
      @(negedge k_pos);
      #40 ctrl_d = ~w1;
      byte_write_n = 4'hf;
   endtask : wr_burst
endmodule : dsr_ctrl_model

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the burst-of-two SRAM pin interface
// Assumes: Controller model makes the 160 ns link clock; clk is 20 ns
// Notes: Read latency is counted in clk cycles from the command rise
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [35:0] W0 = 36'h123456789;
   localparam logic [35:0] W1 = 36'h9abcdef01;
   localparam logic [35:0] W2 = 36'h0f0f0f0f0;
   localparam logic [35:0] W3 = 36'hf0f0f0f0f;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic dll_bypass_n = 1'b1;
   logic k_pos, k_neg, c_pos, c_neg, load_n, dir_select, oe0;
   logic [3:0] byte_write_n;
   logic [7:0] addr_in;
   logic [35:0] data_i, data_o, data_oe;
   logic echo_strobe_pos, echo_strobe_neg, dll_locked;
   int n_fail = 0;
   int total_checks = 0;

   dsr_ctrl_model ctl (.k_pos(k_pos), .k_neg(k_neg), .c_pos(c_pos), .c_neg(c_neg),
      .load_n(load_n), .dir_select(dir_select), .byte_write_n(byte_write_n),
      .addr_in(addr_in), .data_i(data_i), .dev_d(data_o), .dev_oe(data_oe));
   dsr_sram_port #(.ADDR_W(8), .TIE_CYC(16), .LOCK_CYC(8)) uut (.clk(clk), .srst(srst),
      .in_timing_pos(k_pos), .in_timing_neg(k_neg), .out_timing_pos(c_pos),
      .out_timing_neg(c_neg), .dll_bypass_n(dll_bypass_n), .load_n(load_n),
      .dir_select(dir_select), .byte_write_n(byte_write_n), .addr_in(addr_in),
      .data_i(data_i), .data_o(data_o), .data_oe(data_oe), .echo_strobe_pos(echo_strobe_pos),
      .echo_strobe_neg(echo_strobe_neg), .dll_locked(dll_locked));

   always_comb oe0 = data_oe[0];
   initial begin
      forever #10 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick

   // Bounded wait; running out ends the run
   task automatic wait_hi(ref logic sig, output int n);
      n = 0;
      while (sig !== 1'b1) begin
         tick(1);
         n++;
         if (n > 40) begin
            n_fail++;
            $display("MISMATCH at %0t: wait ran out", $time);
            tally_and_finish();
         end
      end
   endtask : wait_hi

   function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] w,
                                         input logic [3:0] bw);
      for (int i = 0; i < 4; i++) begin
         if (!bw[i]) o[i*9 +: 9] = w[i*9 +: 9];
      end
      return o;
   endfunction : merge

   // One or two back-to-back reads; words sampled mid-window
   task automatic rd(input logic two, input logic [7:0] a0, input logic [7:0] a1,
                     input int lo, input int hi, input logic [143:0] e);
      int n;
      ctl.command(1'b1, a0);
      fork
         begin
            if (two) ctl.command(1'b1, a1);
            ctl.idle();
         end
      join_none
      wait_hi(oe0, n);
      check(36'(n >= lo && n <= hi), 36'h1, "read latency");
      tick(1);
      for (int k = 0; k < (two ? 4 : 2); k++) begin
         check(data_o, e[143-36*k -: 36], "read word");
         check(data_oe, '1, "drive all lines");
         check(36'(k[0] ? echo_strobe_pos : echo_strobe_neg), 36'h1, "echo edge");
         tick(4);
      end
      check(data_oe, 36'h0, "bus release");
   endtask : rd

   task automatic t_dll();
      int n;
      check(data_oe, 36'h0, "bus after reset");
      // Lock first, so the bypass check sees a real clear
      wait_hi(dll_locked, n);
      check(36'(dll_locked), 36'h1, "lock before bypass");
      dll_bypass_n = 1'b0;
      tick(4);
      check(36'(dll_locked), 36'h0, "lock cleared");
      dll_bypass_n = 1'b1;
      wait_hi(dll_locked, n);
      check(36'(n >= 8 && n <= 14), 36'h1, "lock time");
      $display("Done: dll lock");
   endtask : t_dll

   task automatic t_wr_rd();
      ctl.wr_burst(8'h12, W0, W1, 4'h0, 4'h0);
      ctl.wr_burst(8'h13, W2, W3, 4'h0, 4'h0);
      rd(1'b1, 8'h12, 8'h13, 14, 16, {W0, W1, W2, W3});
      $display("Done: write and read back");
   endtask : t_wr_rd

   task automatic t_lanes();
      ctl.wr_burst(8'h12, '1, '0, 4'ha, 4'h5);
      rd(1'b0, 8'h12, 8'h00, 14, 16, {merge(W0, '1, 4'ha), merge(W1, '0, 4'h5), 72'h0});
      $display("Done: byte lanes");
   endtask : t_lanes

   task automatic t_skew();
      ctl.skew_ns = 60;
      tick(16);
      rd(1'b0, 8'h13, 8'h00, 17, 19, {W2, W3, 72'h0});
      $display("Done: skewed output clocks");
   endtask : t_skew

   task automatic t_tied();
      ctl.tie_c = 1'b1;
      tick(24);
      rd(1'b0, 8'h13, 8'h00, 14, 16, {W2, W3, 72'h0});
      $display("Done: output clocks tied");
   endtask : t_tied

   task automatic t_no_dll();
      dll_bypass_n = 1'b0;
      tick(8);
      rd(1'b1, 8'h13, 8'h12, 6, 8, {W2, W3, merge(W0, '1, 4'ha), merge(W1, '0, 4'h5)});
      $display("Done: dll bypassed");
   endtask : t_no_dll

   task automatic t_echo();
      int n;
      logic last;
      n = 0;
      last = echo_strobe_pos;
      repeat (64) begin
         tick(1);
         if (echo_strobe_pos !== last) n++;
         last = echo_strobe_pos;
         check(data_oe, 36'h0, "idle release");
      end
      check(36'(n >= 15 && n <= 17), 36'h1, "echo toggles");
      check(36'(echo_strobe_neg ^ echo_strobe_pos), 36'h1, "echo pair");
      $display("Done: free echo");
   endtask : t_echo

   initial begin
      tick(2);
      srst = 1'b0;
      t_dll();
      t_wr_rd();
      t_lanes();
      t_skew();
      t_tied();
      t_no_dll();
      t_echo();
      tally_and_finish();
   end
endmodule : tb_top
